// file: ssrh_pkg.sv
package ssrh_pkg;
  localparam int unsigned     BYTE_BITS        = 8;
  localparam logic [1:0]      CLKSEL_DIV8      = 2'h0;
  localparam logic [1:0]      CLKSEL_DIV4      = 2'h1;
  localparam logic [1:0]      CLKSEL_DIV2      = 2'h2;
  localparam logic [1:0]      CLKSEL_EXT       = 2'h3;
  localparam logic [1:0]      PORTSEL_RESET    = 2'h0;
  localparam logic [1:0]      PORTSEL_ALL      = 2'h3;
  localparam logic [3:0]      CNT_BYTE_DONE    = 4'h8;
  localparam logic [7:0]      SHIFT_RESET      = 8'h00;
  localparam logic            PIN_LATCH_RESET  = 1'b1;
  localparam int unsigned     BUF_DEPTH        = 2;

  typedef enum logic [1:0] {
    SSRH_ST_IDLE,
    SSRH_ST_ARMED,
    SSRH_ST_WAIT_READY,
    SSRH_ST_SHIFT
  } ssrh_state_t;

  // Half-period of the internal shift clock, in reference-clock cycles.
  function automatic logic [2:0] ssrh_half_period(input logic [1:0] sel);
    case (sel)
      CLKSEL_DIV8: ssrh_half_period = 3'h4;
      CLKSEL_DIV4: ssrh_half_period = 3'h2;
      default:     ssrh_half_period = 3'h1;
    endcase
  endfunction
endpackage

// file: ssrh_link_if.sv
`timescale 1ns/10ps
interface ssrh_link_if;
  logic sck_mst_o;
  logic sck_mst_oe;
  logic sck_slv_o;
  logic sck_slv_oe;
  logic sck;
  logic sdat_mst_o;
  logic sdat_mst_oe;
  logic sdat_slv_o;
  logic sdat_slv_oe;
  logic sdat;
  logic ready_o;
  logic ready_oe;
  logic ready;

  // Pulled-up open wires: high unless a driver pulls them low.
  assign sck   = (sck_mst_oe & ~sck_mst_o) | (sck_slv_oe & ~sck_slv_o) ? 1'b0 : 1'b1;
  assign sdat  = (sdat_mst_oe & ~sdat_mst_o) | (sdat_slv_oe & ~sdat_slv_o) ? 1'b0 : 1'b1;
  assign ready = (ready_oe & ~ready_o) ? 1'b0 : 1'b1;

  modport master (
    output sck_mst_o,
    output sck_mst_oe,
    output sdat_mst_o,
    output sdat_mst_oe,
    input  sck,
    input  sdat,
    input  ready
  );
  modport slave (
    output sck_slv_o,
    output sck_slv_oe,
    output sdat_slv_o,
    output sdat_slv_oe,
    output ready_o,
    output ready_oe,
    input  sck,
    input  sdat
  );
endinterface

// file: ssrh_slave.sv
`timescale 1ns/10ps
// Notes on behaviour
// (R1) Master takes ready line as input.
// (R2) Slave drives ready high during setup.
// (R3) Master loads shift register before transfer.
// (R4) Start clears done flag, arms reception.
// (R5) Slave drops ready only after arming.
// (R6) Master starts only when ready low.
// (R7) Slave raises ready once done seen.
// (R8) One byte per pass, repeat continuous.
// (R9) External clock never gated; always shifts. The slave drops a rise that comes in the cycle of start_transfer_op.
// (R10) Done after eight external counts.
// (R11) Clock source limits pulses to transfer.
// (R12) External clock idles high.
// (R13) Reset: pins released, latches one.
// (R14) LSB first out bit0, in bit7.
// (R15) Select div8, div4, div2 or external; the master runs external at the div2 rate.
// (R16) Done cleared on interrupt or skip.
// (R17) Drive on falling, sample on rising.
// (R18) Internal clock: eight pulses, idle high.
module ssrh_slave
  import ssrh_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  ssrh_link_if.slave       link,
  input  wire logic        start_transfer_op,
  input  wire logic        port_enable,
  input  wire logic        done_ack,
  output logic             transfer_done_flag,
  output logic             irq_pulse,
  input  wire logic        intctl_irq_en,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data
);
  logic [1:0]  sck_sync_ff;
  logic [1:0]  nxt_sck_sync;
  logic [1:0]  sin_sync_ff;
  logic [1:0]  nxt_sin_sync;
  logic        sck_prev_ff;
  logic        nxt_sck_prev;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_shift;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic        armed_ff;
  logic        nxt_armed;
  logic        done_ff;
  logic        nxt_done;
  logic        ready_ff;
  logic        nxt_ready;
  logic [7:0]  buf_ff [BUF_DEPTH];
  logic [7:0]  nxt_buf [BUF_DEPTH];
  logic [1:0]  bcnt_ff;
  logic [1:0]  nxt_bcnt;
  logic        wr_idx_ff;
  logic        nxt_wr_idx;
  logic        rd_idx_ff;
  logic        nxt_rd_idx;
  logic        sck_rise;
  logic        byte_end;
  logic        push;
  logic        pop;

  // Bits enter at the top, so the first bit received ends at bit 0. R14
  function automatic logic [7:0] shift_in_lsb(input logic [7:0] cur, input logic bit_in);
    shift_in_lsb = {bit_in, cur[7:1]};
  endfunction

  assign sck_rise = sck_sync_ff[1] & ~sck_prev_ff;

  // Clock and data pass the same two flops, so they stay aligned to each other.
  always_comb begin
    nxt_sck_sync = {sck_sync_ff[0], link.sck};
    nxt_sin_sync = {sin_sync_ff[0], link.sdat};
    nxt_sck_prev = sck_sync_ff[1];
  end

  // The flops start at the pulled-up idle level, so no false clock edge follows reset.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sck_sync_ff <= 2'h3;
      sin_sync_ff <= 2'h3;
      sck_prev_ff <= 1'b1;
    end else begin
      sck_sync_ff <= nxt_sck_sync;
      sin_sync_ff <= nxt_sin_sync;
      sck_prev_ff <= nxt_sck_prev;
    end
  end

  always_comb begin
    nxt_shift = shift_ff;
    nxt_cnt   = cnt_ff;
    nxt_armed = armed_ff;
    nxt_done  = done_ff;
    byte_end  = 1'b0;
    if (start_transfer_op) begin
      nxt_done  = 1'b0; // R4
      nxt_armed = 1'b1; // R4
      nxt_cnt   = 4'h0;
    end else begin
      // Every incoming clock shifts, even after the byte, except one in the cycle of start_transfer_op; only arming counts. R9
      if (sck_rise) begin
        nxt_shift = shift_in_lsb(shift_ff, sin_sync_ff[1]); // R14 R17
        if (armed_ff && cnt_ff == CNT_BYTE_DONE - 4'h1) begin
          byte_end  = 1'b1;
          nxt_armed = 1'b0;
          nxt_cnt   = CNT_BYTE_DONE;
        end else if (armed_ff) begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      if (done_ack || (intctl_irq_en && done_ff)) begin
        nxt_done = 1'b0; // R16
      end
      // A byte that ends in the cycle of a clear still sets the flag.
      if (byte_end) begin
        nxt_done = 1'b1; // R10
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift_ff <= SHIFT_RESET;
      cnt_ff   <= 4'h0;
      armed_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      cnt_ff   <= nxt_cnt;
      armed_ff <= nxt_armed;
      done_ff  <= nxt_done;
    end
  end

  // Ready stays high until armed, drops after arming, rises once done. R2 R5 R7
  // It rises in the cycle the flag is set, so the master never starts a byte early.
  always_comb begin
    nxt_ready = ready_ff;
    if (!port_enable || byte_end || done_ff) begin
      nxt_ready = 1'b1;
    end else if (armed_ff) begin
      nxt_ready = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready_ff <= PIN_LATCH_RESET; // R13
    end else begin
      ready_ff <= nxt_ready;
    end
  end

  // Two-entry buffer keeps a finished byte if the consumer stalls.
  // A byte that finds both entries full is dropped; the flag still reports it.
  assign push     = byte_end && bcnt_ff != 2'(BUF_DEPTH);
  assign pop      = rx_valid && rx_ready;
  assign rx_valid = bcnt_ff != 2'h0;
  assign rx_data  = buf_ff[rd_idx_ff];

  // Entries stay in place and two indices walk over them, so no byte is copied.
  always_comb begin
    nxt_buf    = buf_ff;
    nxt_wr_idx = wr_idx_ff;
    nxt_rd_idx = rd_idx_ff;
    nxt_bcnt   = bcnt_ff;
    if (push) begin
      nxt_buf[wr_idx_ff] = shift_in_lsb(shift_ff, sin_sync_ff[1]); // R14
      nxt_wr_idx         = ~wr_idx_ff;
    end
    if (pop) begin
      nxt_rd_idx = ~rd_idx_ff;
    end
    case ({push, pop})
      2'b10:   nxt_bcnt = bcnt_ff + 2'h1;
      2'b01:   nxt_bcnt = bcnt_ff - 2'h1;
      default: nxt_bcnt = bcnt_ff;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      buf_ff[0] <= 8'h00;
      buf_ff[1] <= 8'h00;
      wr_idx_ff <= 1'b0;
      rd_idx_ff <= 1'b0;
      bcnt_ff   <= 2'h0;
    end else begin
      buf_ff    <= nxt_buf;
      wr_idx_ff <= nxt_wr_idx;
      rd_idx_ff <= nxt_rd_idx;
      bcnt_ff   <= nxt_bcnt;
    end
  end

  assign transfer_done_flag = done_ff;
  assign irq_pulse          = intctl_irq_en & done_ff; // R16
  // Slave uses the external clock: never drives the clock pin. R9 R13
  assign link.sck_slv_o     = PIN_LATCH_RESET;
  assign link.sck_slv_oe    = 1'b0;
  // The single data wire carries master to slave; driving it here would corrupt the byte.
  assign link.sdat_slv_o    = PIN_LATCH_RESET;
  assign link.sdat_slv_oe   = 1'b0; // R13
  assign link.ready_o       = ready_ff;
  assign link.ready_oe      = port_enable; // R13
endmodule

// file: ssrh_master.sv
`timescale 1ns/10ps
module ssrh_master
  import ssrh_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  ssrh_link_if.master      link,
  input  wire logic [1:0]  clk_select,
  input  wire logic        port_enable,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  output logic             transfer_done_flag,
  input  wire logic        done_ack
);
  ssrh_state_t st_ff;
  ssrh_state_t nxt_st;
  logic [1:0]  rdy_sync_ff;
  logic [1:0]  nxt_rdy_sync;
  logic [7:0]  shift_ff;
  logic [7:0]  nxt_shift;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt;
  logic [2:0]  div_ff;
  logic [2:0]  nxt_div;
  logic        sck_ff;
  logic        nxt_sck;
  logic        done_ff;
  logic        nxt_done;
  logic        sdat_ff;
  logic        nxt_sdat;

  assign tx_ready = st_ff == SSRH_ST_IDLE && port_enable;

  always_comb begin
    nxt_rdy_sync = {rdy_sync_ff[0], link.ready}; // R1
    nxt_st       = st_ff;
    nxt_shift    = shift_ff;
    nxt_cnt      = cnt_ff;
    nxt_div      = div_ff;
    nxt_sck      = sck_ff;
    nxt_done     = done_ff;
    nxt_sdat     = sdat_ff;
    if (done_ack) begin
      nxt_done = 1'b0; // R16
    end
    case (st_ff)
      SSRH_ST_IDLE: begin
        nxt_sck = 1'b1; // R12
        if (tx_valid && tx_ready) begin
          nxt_shift = tx_data; // R3 R8
          nxt_st    = SSRH_ST_WAIT_READY;
        end
      end
      SSRH_ST_WAIT_READY: begin
        if (!rdy_sync_ff[1]) begin
          nxt_done = 1'b0; // R6
          nxt_cnt  = 4'h0;
          nxt_div  = ssrh_half_period(clk_select); // R15
          nxt_sck  = 1'b0; // R17
          nxt_sdat = shift_ff[0]; // R14 R17
          nxt_st   = SSRH_ST_SHIFT;
        end
      end
      SSRH_ST_SHIFT: begin
        if (div_ff > 3'h1) begin
          nxt_div = div_ff - 3'h1;
        end else begin
          nxt_div = ssrh_half_period(clk_select);
          nxt_sck = ~sck_ff;
          if (!sck_ff) begin
            nxt_cnt = cnt_ff + 4'h1;
          end else begin
            nxt_shift = {1'b1, shift_ff[7:1]}; // R14 R17
            nxt_sdat  = shift_ff[1];
          end
          if (!sck_ff && cnt_ff == CNT_BYTE_DONE - 4'h1) begin
            nxt_done = 1'b1; // R18
            nxt_st   = SSRH_ST_IDLE;
          end
        end
      end
      default: nxt_st = SSRH_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_ff       <= SSRH_ST_IDLE;
      rdy_sync_ff <= 2'h3;
      shift_ff    <= SHIFT_RESET;
      cnt_ff      <= 4'h0;
      div_ff      <= 3'h0;
      sck_ff      <= PIN_LATCH_RESET; // R13
      done_ff     <= 1'b0;
      sdat_ff     <= PIN_LATCH_RESET; // R13
    end else begin
      st_ff       <= nxt_st;
      rdy_sync_ff <= nxt_rdy_sync;
      shift_ff    <= nxt_shift;
      cnt_ff      <= nxt_cnt;
      div_ff      <= nxt_div;
      sck_ff      <= nxt_sck;
      done_ff     <= nxt_done;
      sdat_ff     <= nxt_sdat;
    end
  end

  assign transfer_done_flag = done_ff;
  // Clock pin driven low only; high comes from the pull-up.
  assign link.sck_mst_o     = sck_ff;
  assign link.sck_mst_oe    = port_enable & ~sck_ff;
  // The last bit stays on the pin after the byte, so the eighth rise never sees it move.
  assign link.sdat_mst_o    = sdat_ff; // R14
  assign link.sdat_mst_oe   = port_enable & ~sdat_ff;
endmodule

// file: ssrh_link_sva.sv
`timescale 1ns/10ps
module ssrh_link_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic sck_mst_oe,
  input wire logic sdat_mst_oe,
  input wire logic sck_slv_oe,
  input wire logic sdat_slv_oe,
  input wire logic ready_o,
  input wire logic sck,
  input wire logic sdat,
  input wire logic ready
);
  logic [3:0] rise_cnt_ff;
  logic [3:0] nxt_rise_cnt;
  logic       sck_q_ff;
  logic       rdy_q_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Rises of the shift clock since ready last rose, so one count per byte.
  always_comb begin
    nxt_rise_cnt = rise_cnt_ff;
    if (ready && !rdy_q_ff) begin
      nxt_rise_cnt = 4'h0;
    end else if (sck && !sck_q_ff) begin
      nxt_rise_cnt = rise_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rise_cnt_ff <= 4'h0;
      sck_q_ff    <= 1'b1;
      rdy_q_ff    <= 1'b1;
    end else begin
      rise_cnt_ff <= nxt_rise_cnt;
      sck_q_ff    <= sck;
      rdy_q_ff    <= ready;
    end
  end

  property p_rst_oe;
    disable iff (1'b0) sys_rst |=> !(sck_mst_oe | sdat_mst_oe | sck_slv_oe | sdat_slv_oe);
  endproperty
  property p_rst_latch;
    disable iff (1'b0) sys_rst |=> ready_o;
  endproperty
  property p_start_rdy;
    $fell(sck) |-> !ready;
  endproperty
  property p_sample_stable;
    $rose(sck) |-> $stable(sdat);
  endproperty
  property p_max_eight;
    $rose(sck) |-> rise_cnt_ff < 4'h8;
  endproperty
  property p_idle_high;
    rise_cnt_ff == 4'h8 |-> sck;
  endproperty
  property p_done_ready;
    $rose(sck) && rise_cnt_ff == 4'h7 |-> ##[1:12] $rose(ready);
  endproperty
  property p_hold_low;
    !ready && rise_cnt_ff != 4'h8 |=> !ready;
  endproperty

  a_rst_oe:        assert property (p_rst_oe) else $error("pins driven after reset");
  a_rst_latch:     assert property (p_rst_latch) else $error("ready latch not one");
  a_start_rdy:     assert property (p_start_rdy) else $error("clock while ready high");
  a_sample_stable: assert property (p_sample_stable) else $error("data moved on rise");
  a_max_eight:     assert property (p_max_eight) else $error("ninth clock rise");
  a_idle_high:     assert property (p_idle_high) else $error("clock not idle high");
  a_done_ready:    assert property (p_done_ready) else $error("ready not raised");
  a_hold_low:      assert property (p_hold_low) else $error("ready rose early");

  c_byte_end:  cover property (rise_cnt_ff == 4'h8);
  c_ready_up:  cover property ($rose(ready));
  c_ready_low: cover property ($fell(ready));
endmodule

// file: tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(negedge ref_clk); n++; end end
module tb;
  import ssrh_pkg::*;
  logic       ref_clk, sys_rst, start_op, port_en, m_ack, s_ack, irq_en;
  logic       s_done, m_done, irq, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [1:0] clk_sel;
  logic [7:0] rx_data, tx_data;
  logic [7:0] pats [4] = '{8'h01, 8'h80, 8'ha5, 8'h3c};
  int         n, cyc, bad_count, checks;

  ssrh_link_if lnk ();
  ssrh_master i_ssrh_master (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lnk),
    .clk_select(clk_sel), .port_enable(port_en), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .transfer_done_flag(m_done), .done_ack(m_ack));
  ssrh_slave i_ssrh_slave (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(lnk),
    .start_transfer_op(start_op), .port_enable(port_en), .done_ack(s_ack),
    .transfer_done_flag(s_done), .irq_pulse(irq), .intctl_irq_en(irq_en),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
  ssrh_link_sva i_ssrh_link_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sck_mst_oe(lnk.sck_mst_oe), .sdat_mst_oe(lnk.sdat_mst_oe), .sck_slv_oe(lnk.sck_slv_oe),
    .sdat_slv_oe(lnk.sdat_slv_oe), .ready_o(lnk.ready_o), .sck(lnk.sck),
    .sdat(lnk.sdat), .ready(lnk.ready));

  task automatic wrap_up;
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Slave arms first, master loads and waits for ready; slave done is acked only on odd bytes.
  task automatic xfer(input logic [7:0] b);
    @(negedge ref_clk);
    start_op = 1'b1;
    @(negedge ref_clk);
    start_op = 1'b0;
    `CHK(s_done, 1'b0)
    @(negedge ref_clk);
    `CHK(lnk.ready, 1'b0)
    tx_valid = 1'b1;
    tx_data  = b;
    while (tx_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    tx_valid = 1'b0;
    `WAITC(s_done === 1'b1)
    `CHK({m_done, irq}, {1'b1, irq_en})
    @(negedge ref_clk);
    `CHK(lnk.ready, 1'b1)
    if (irq_en) `CHK(s_done, 1'b0)
    m_ack = 1'b1;
    s_ack = b[0];
    @(negedge ref_clk);
    m_ack = 1'b0;
    s_ack = 1'b0;
    `CHK({m_done, s_done & b[0]}, 2'h0)
  endtask

  task automatic pop(input logic [7:0] b);
    `WAITC(rx_valid === 1'b1)
    `CHK(rx_data, b)
    rx_ready = 1'b1;
    @(negedge ref_clk);
    rx_ready = 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up;
    end
  end

  initial begin
    {sys_rst, port_en} = 2'h3;
    {start_op, m_ack, s_ack, irq_en, rx_ready, tx_valid} = 6'h00;
    tx_data = 8'h00;
    clk_sel = CLKSEL_DIV8;
    repeat (8) @(negedge ref_clk);
    `CHK({lnk.sck_mst_oe, lnk.sdat_mst_oe, lnk.sck_slv_oe, lnk.sdat_slv_oe}, 4'h0)
    `CHK({lnk.sck, lnk.sdat, lnk.ready}, 3'h7)
    sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      clk_sel = i[1:0];
      xfer(pats[i]);
      pop(pats[i]);
    end
    irq_en = 1'b1;
    xfer(8'h5a);
    pop(8'h5a);
    irq_en = 1'b0;
    xfer(8'hc3);
    xfer(8'h96);
    xfer(8'h0f);
    pop(8'hc3);
    pop(8'h96);
    repeat (4) @(negedge ref_clk);
    `CHK(rx_valid, 1'b0)
    wrap_up;
  end
endmodule
